// >>> core/trap_and_trigger_csr_bank.sv
`timescale 1ns/100ps
// How it works
// [R1] exception saves current pc into trap return pc, then fetch goes to handler
// [R2] trap return instruction loads pc from trap return pc register
// [R3] trap return pc bits 31:1 writable, bit 0 reads zero
// [R4] cause bit 31 set for interrupts, cleared for exceptions
// [R5] cause bits 30:5 read zero, bits 4:0 writable code
// [R6] software writes only legal codes into the cause code field
// [R7] trap value ignores writes and reads zero
// [R8] pending bits 31:16 show fast interrupt lines
// [R9] pending bits 11, 7, 3 show external, timer, software lines
// [R10] trigger select reads zero, writes ignored
// [R11] trigger, context and info registers reachable only in debug or machine mode
// [R12] trigger control and match address writable only from debug mode
// [R13] trigger type reads 2, machine match bit 6 reads one
// [R14] action field reads 1; a match enters debug mode
// [R15] timing bit zero; break happens before matching instruction executes
// [R16] mask and match kind read zero; exact whole-address compare
// [R17] execute bit 2 writable, enables instruction address matching
// [R18] match address register holds 32-bit compare address
// [R19] extra data and context registers ignore writes, read zero
// [R20] info reads 0x4, or 1 if selected trigger is absent
// [R21] load, store, chain, hit, select, s and u fields read zero
// [R22] handler fetched from trap vector bits 31:8
// [R23] interrupt line enabled only when its enable bit is set
// [R24] taken interrupt saves first uncompleted instruction address
// [R25] scratch is plain read/write word resetting to zero
module trap_and_trigger_csr_bank
    import trap_csr_pkg::*;
#(
    parameter int FAST_IRQ_W = 16
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire csr_req_s    csr_req,
    input  wire logic        debug_mode,
    input  wire logic        machine_mode,
    output logic [31:0]      csr_rdata,
    output logic             csr_illegal,
    input  wire trap_event_s trap_event,
    input  wire logic        trap_return,
    input  wire logic [31:0] trap_vector,
    input  wire logic [31:0] irq_lines,
    input  wire logic [31:0] irq_enable,
    output logic [31:0]      irq_enabled_pending,
    input  wire logic        fetch_valid,
    input  wire logic [31:0] fetch_addr,
    output logic             pc_redirect,
    output logic [31:0]      pc_redirect_addr,
    output logic             debug_enter
);

    // the pending view only serves the full set of sixteen fast lines
    if (FAST_IRQ_W != 16) begin : g_width_check
        $error("fast interrupt width must be 16");
    end

    // ------------------------------------------------------------
    // input synchronisers for irq pins
    // ------------------------------------------------------------
    logic [31:0] irq_meta_r;
    logic [31:0] irq_sync_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_meta_r <= RESET_ZERO;
            irq_sync_r <= RESET_ZERO;
        end else begin
            irq_meta_r <= irq_lines;
            irq_sync_r <= irq_meta_r;
        end
    end

    // ------------------------------------------------------------
    // address decode and write data
    // ------------------------------------------------------------
    logic        trig_space;
    logic        priv_ok;
    logic        known;
    logic        wr;
    logic [31:0] old_val;
    logic [31:0] new_val;

    assign trig_space = (csr_req.addr[11:4] == ADDR_TRIGGER_SELECT[11:4]);
    assign priv_ok    = !trig_space || debug_mode || machine_mode; // [R11]

    always_comb begin
        case (csr_req.addr)
            ADDR_MACHINE_SCRATCH, ADDR_TRAP_RETURN_PC, ADDR_TRAP_CAUSE,
            ADDR_TRAP_VALUE, ADDR_INTERRUPT_PENDING, ADDR_TRIGGER_SELECT,
            ADDR_TRIGGER_CONTROL, ADDR_TRIGGER_MATCH_ADDRESS,
            ADDR_TRIGGER_EXTRA_DATA, ADDR_TRIGGER_TYPE_INFO,
            ADDR_MACHINE_CONTEXT_ID, ADDR_SUPERVISOR_CONTEXT_ID: known = 1'b1;
            default: known = 1'b0;
        endcase
    end

    assign csr_illegal = csr_req.valid && !(known && priv_ok);
    assign wr = csr_req.valid && known && priv_ok && (csr_req.op != CSR_OP_READ);

    always_comb begin
        case (csr_req.op)
            CSR_OP_WRITE: new_val = csr_req.wdata;
            CSR_OP_SET:   new_val = old_val | csr_req.wdata;
            CSR_OP_CLEAR: new_val = old_val & ~csr_req.wdata;
            default:      new_val = old_val;
        endcase
    end

    // ------------------------------------------------------------
    // trap registers
    // ------------------------------------------------------------
    logic [31:0] scratch_r;
    logic [31:0] return_pc_r;
    logic        cause_irq_r;
    logic [4:0]  cause_code_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            scratch_r <= RESET_ZERO; // [R25]
        end else if (wr && csr_req.addr == ADDR_MACHINE_SCRATCH) begin
            scratch_r <= new_val; // [R25]
        end
    end

    // trap capture beats a same-cycle software write
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            return_pc_r <= RESET_ZERO;
        end else if (trap_event.take) begin
            return_pc_r <= trap_event.pc & RETURN_PC_MASK; // [R1] [R24] [R3]
        end else if (wr && csr_req.addr == ADDR_TRAP_RETURN_PC) begin
            return_pc_r <= new_val & RETURN_PC_MASK; // [R3]
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cause_irq_r  <= 1'b0;
            cause_code_r <= 5'h00;
        end else if (trap_event.take) begin
            cause_irq_r  <= trap_event.is_irq; // [R4]
            cause_code_r <= trap_event.code;
        end else if (wr && csr_req.addr == ADDR_TRAP_CAUSE) begin
            cause_irq_r  <= new_val[CAUSE_IRQ_BIT];
            cause_code_r <= new_val[CAUSE_CODE_W-1:0]; // [R5] [R6] legality is software's
        end
    end

    // ------------------------------------------------------------
    // trigger registers
    // ------------------------------------------------------------
    logic        execute_r;
    logic [31:0] match_addr_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            execute_r    <= TRIGGER_CONTROL_FIXED[TCTRL_EXECUTE_BIT];
            match_addr_r <= RESET_ZERO;
        end else if (wr && debug_mode) begin // [R12]
            if (csr_req.addr == ADDR_TRIGGER_CONTROL) begin
                execute_r <= new_val[TCTRL_EXECUTE_BIT]; // [R17]
            end
            if (csr_req.addr == ADDR_TRIGGER_MATCH_ADDRESS) begin
                match_addr_r <= new_val; // [R18]
            end
        end
    end

    logic [31:0] tctrl_val;
    always_comb begin
        tctrl_val = TRIGGER_CONTROL_FIXED; // [R13] [R14] [R15] [R16] [R21]
        tctrl_val[TCTRL_EXECUTE_BIT] = execute_r;
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    always_comb begin
        case (csr_req.addr)
            ADDR_MACHINE_SCRATCH:       old_val = scratch_r;
            ADDR_TRAP_RETURN_PC:        old_val = return_pc_r; // [R3]
            ADDR_TRAP_CAUSE:            old_val = {cause_irq_r, 26'h0, cause_code_r}; // [R5]
            ADDR_TRAP_VALUE:            old_val = RESET_ZERO; // [R7]
            ADDR_INTERRUPT_PENDING:     old_val = irq_sync_r & PENDING_MASK; // [R8] [R9]
            ADDR_TRIGGER_SELECT:        old_val = RESET_ZERO; // [R10]
            ADDR_TRIGGER_CONTROL:       old_val = tctrl_val;
            ADDR_TRIGGER_MATCH_ADDRESS: old_val = match_addr_r;
            ADDR_TRIGGER_TYPE_INFO:     old_val = TRIGGER_INFO_PRESENT; // [R20]
            default:                    old_val = RESET_ZERO; // [R19]
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            csr_rdata <= RESET_ZERO;
        end else if (csr_req.valid && known && priv_ok) begin
            csr_rdata <= old_val;
        end
    end

    // ------------------------------------------------------------
    // pending and enabled interrupt view
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            irq_enabled_pending <= RESET_ZERO;
        end else begin
            irq_enabled_pending <= irq_sync_r & PENDING_MASK & irq_enable; // [R23]
        end
    end

    // ------------------------------------------------------------
    // redirect and breakpoint
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pc_redirect      <= 1'b0;
            pc_redirect_addr <= RESET_ZERO;
        end else begin
            pc_redirect <= trap_event.take || trap_return;
            if (trap_event.take) begin
                pc_redirect_addr <= trap_vector & VECTOR_BASE_MASK; // [R1] [R22]
            end else if (trap_return) begin
                pc_redirect_addr <= return_pc_r; // [R2]
            end
        end
    end

    // match flagged on fetch so the instruction never executes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            debug_enter <= 1'b0;
        end else begin
            debug_enter <= fetch_valid && execute_r && !debug_mode
                           && (fetch_addr == match_addr_r); // [R14] [R15] [R16] [R17]
        end
    end

endmodule

// >>> core/trap_csr_pkg.sv
package trap_csr_pkg;

    // ------------------------------------------------------------
    // csr addresses
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_MACHINE_SCRATCH        = 12'h340;
    localparam logic [11:0] ADDR_TRAP_RETURN_PC         = 12'h341;
    localparam logic [11:0] ADDR_TRAP_CAUSE             = 12'h342;
    localparam logic [11:0] ADDR_TRAP_VALUE             = 12'h343;
    localparam logic [11:0] ADDR_INTERRUPT_PENDING      = 12'h344;
    localparam logic [11:0] ADDR_TRIGGER_SELECT         = 12'h7a0;
    localparam logic [11:0] ADDR_TRIGGER_CONTROL        = 12'h7a1;
    localparam logic [11:0] ADDR_TRIGGER_MATCH_ADDRESS  = 12'h7a2;
    localparam logic [11:0] ADDR_TRIGGER_EXTRA_DATA     = 12'h7a3;
    localparam logic [11:0] ADDR_TRIGGER_TYPE_INFO      = 12'h7a4;
    localparam logic [11:0] ADDR_MACHINE_CONTEXT_ID     = 12'h7a8;
    localparam logic [11:0] ADDR_SUPERVISOR_CONTEXT_ID  = 12'h7aa;

    // ------------------------------------------------------------
    // reset values and field layouts
    // ------------------------------------------------------------
    localparam logic [31:0] RESET_ZERO             = 32'h0000_0000;
    localparam logic [31:0] TRIGGER_CONTROL_FIXED  = 32'h2800_1040;
    localparam logic [31:0] TRIGGER_INFO_PRESENT   = 32'h0000_0004;
    localparam logic [31:0] TRIGGER_INFO_ABSENT    = 32'h0000_0001;
    localparam int          TCTRL_EXECUTE_BIT      = 2;
    localparam int          CAUSE_IRQ_BIT          = 31;
    localparam int          CAUSE_CODE_W           = 5;
    localparam logic [31:0] PENDING_MASK           = 32'hffff_0888;
    localparam logic [31:0] RETURN_PC_MASK         = 32'hffff_fffe;
    localparam int          VECTOR_BASE_LSB        = 8;
    localparam logic [31:0] VECTOR_BASE_MASK       = 32'hffff_ff00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CSR_OP_WRITE,
        CSR_OP_SET,
        CSR_OP_CLEAR,
        CSR_OP_READ
    } csr_op_e;

    typedef struct packed {
        logic        valid;
        csr_op_e     op;
        logic [11:0] addr;
        logic [31:0] wdata;
    } csr_req_s;

    typedef struct packed {
        logic        take;
        logic        is_irq;
        logic [4:0]  code;
        logic [31:0] pc;
    } trap_event_s;

endpackage

// >>> testbench/irq_pin_model.sv
`timescale 1ns/100ps
// request pins follow the wanted level just after each edge
module irq_pin_model (
    input  wire logic        clk,
    input  wire logic [31:0] want,
    output logic [31:0]      irq_lines
);
    // one process owns the pins: idle low, then follow the wanted level
    initial begin
        irq_lines = 32'h0;
        forever begin
            @(posedge clk);
            irq_lines <= #1 want;
        end
    end
endmodule

// >>> testbench/test_trap_and_trigger_csr_bank.sv
`timescale 1ns/100ps
module test_trap_and_trigger_csr_bank;
    import trap_csr_pkg::*;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    csr_req_s    csr_req = '0;
    logic        debug_mode = 1'b0;
    logic        machine_mode = 1'b1;
    trap_event_s trap_event = '0;
    logic        trap_return = 1'b0;
    logic        fetch_valid = 1'b0;
    logic [31:0] trap_vector = 32'h8000_0123;
    logic [31:0] irq_want = 32'h0;
    logic [31:0] irq_enable = 32'h0;
    logic [31:0] fetch_addr = 32'h0;
    logic [31:0] csr_rdata, irq_lines, irq_enabled_pending, pc_redirect_addr;
    logic        csr_illegal, pc_redirect, debug_enter, ill;
    int          err_total = 0;
    int          n_compared = 0;
    logic [11:0] at [12] = '{12'h340, 12'h341, 12'h342, 12'h343, 12'h344, 12'h7a0,
                             12'h7a1, 12'h7a2, 12'h7a3, 12'h7a4, 12'h7a8, 12'h7aa};
    logic [31:0] rt [12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h2800_1040,
                             32'h0, 32'h0, 32'h4, 32'h0, 32'h0};
    logic [31:0] wt [12] = '{32'hffff_fff7, 32'hffff_fff6, 32'h8000_0017, 32'h0, 32'h0,
                             32'h0, 32'h2800_1040, 32'h0, 32'h0, 32'h4, 32'h0, 32'h0};

    trap_and_trigger_csr_bank dut (.clk, .reset, .csr_req, .debug_mode, .machine_mode,
        .csr_rdata, .csr_illegal, .trap_event, .trap_return, .trap_vector, .irq_lines,
        .irq_enable, .irq_enabled_pending, .fetch_valid, .fetch_addr, .pc_redirect,
        .pc_redirect_addr, .debug_enter);
    irq_pin_model partner (.clk, .want(irq_want), .irq_lines);

    initial forever #2.5 clk = ~clk;
    initial begin
        #20000;
        err_total++;
        finish_test();
    end

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one access; read data is settled when the task returns
    task automatic acc(input csr_op_e op, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        #1 csr_req = '{1'b1, op, a, d};
        #1 ill = csr_illegal;
        @(posedge clk);
        #1 csr_req.valid = 1'b0;
    endtask
    task automatic fetch(input logic [31:0] a, input logic exp);
        fetch_valid = 1'b1;
        fetch_addr = a;
        @(posedge clk);
        #1 fetch_valid = 1'b0;
        chk("breakpoint", {31'h0, debug_enter}, {31'h0, exp});
        @(posedge clk);
        #1;
    endtask
    task automatic pulse(input trap_event_s ev, input logic ret, input logic [31:0] exp);
        trap_event = ev;
        trap_return = ret;
        @(posedge clk);
        #1 trap_event.take = 1'b0;
        trap_return = 1'b0;
        chk("redirect", {31'h0, pc_redirect}, 32'h1);
        chk("target", pc_redirect_addr, exp);
        @(posedge clk);
        #1 chk("redirect end", {31'h0, pc_redirect}, 32'h0);
    endtask

    initial begin
        repeat (16) @(posedge clk);
        #1 reset = 1'b0;
        for (int i = 0; i < 12; i++) begin
            acc(CSR_OP_READ, at[i], 32'h0);
            chk("reset value", csr_rdata, rt[i]);
        end
        for (int i = 0; i < 12; i++) begin
            acc(CSR_OP_WRITE, at[i], 32'hffff_fff7);
            acc(CSR_OP_READ, at[i], 32'h0);
            chk("after write", csr_rdata, wt[i]);
        end
        debug_mode = 1'b1;
        acc(CSR_OP_WRITE, 12'h7a1, 32'hffff_ffff);
        acc(CSR_OP_READ, 12'h7a1, 32'h0);
        chk("control", csr_rdata, 32'h2800_1044);
        acc(CSR_OP_CLEAR, 12'h7a1, 32'h4);
        acc(CSR_OP_READ, 12'h7a1, 32'h0);
        chk("control", csr_rdata, 32'h2800_1040);
        acc(CSR_OP_SET, 12'h7a1, 32'h4);
        acc(CSR_OP_WRITE, 12'h7a2, 32'h0000_1230);
        chk("old match", csr_rdata, 32'h0);
        acc(CSR_OP_READ, 12'h7a2, 32'h0);
        chk("match", csr_rdata, 32'h0000_1230);
        fetch(32'h0000_1230, 1'b0);
        debug_mode = 1'b0;
        fetch(32'h0000_1230, 1'b1);
        fetch(32'h0000_1231, 1'b0);
        pulse('{1'b1, 1'b0, 5'h02, 32'h0000_0a05}, 1'b0, 32'h8000_0100);
        acc(CSR_OP_READ, 12'h341, 32'h0);
        chk("return pc", csr_rdata, 32'h0000_0a04);
        acc(CSR_OP_READ, 12'h342, 32'h0);
        chk("cause", csr_rdata, 32'h0000_0002);
        pulse('{1'b1, 1'b1, 5'h0b, 32'h0000_0b00}, 1'b0, 32'h8000_0100);
        acc(CSR_OP_READ, 12'h342, 32'h0);
        chk("cause", csr_rdata, 32'h8000_000b);
        pulse('0, 1'b1, 32'h0000_0b00);
        irq_want = 32'hffff_ffff;
        irq_enable = 32'h0000_0800;
        repeat (5) @(posedge clk);
        #1 chk("enabled pending", irq_enabled_pending, 32'h0000_0800);
        acc(CSR_OP_READ, 12'h344, 32'h0);
        chk("pending", csr_rdata, 32'hffff_0888);
        machine_mode = 1'b0;
        acc(CSR_OP_READ, 12'h7a1, 32'h0);
        chk("refused", {31'h0, ill}, 32'h1);
        machine_mode = 1'b1;
        finish_test();
    end
endmodule

// >>> testbench/trap_and_trigger_csr_bank_asserts.sv
`timescale 1ns/100ps
module trap_and_trigger_csr_bank_asserts
    import trap_csr_pkg::*;
#(
    parameter int FAST_IRQ_W = 16
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire csr_req_s    csr_req,
    input wire logic        debug_mode,
    input wire logic        machine_mode,
    input wire logic [31:0] csr_rdata,
    input wire logic        csr_illegal,
    input wire trap_event_s trap_event,
    input wire logic        trap_return,
    input wire logic [31:0] trap_vector,
    input wire logic [31:0] irq_lines,
    input wire logic [31:0] irq_enable,
    input wire logic [31:0] irq_enabled_pending,
    input wire logic        fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic        pc_redirect,
    input wire logic [31:0] pc_redirect_addr,
    input wire logic        debug_enter
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_TRAP_TARGET: assert property (trap_event.take |=> pc_redirect &&
        pc_redirect_addr == ($past(trap_vector) & 32'hffff_ff00)) else $error("bad trap target");
    AST_RETURN_JUMP: assert property (trap_return && !trap_event.take |=> pc_redirect)
        else $error("return did not redirect");
    AST_NO_STRAY_JUMP: assert property (!trap_event.take && !trap_return |=> !pc_redirect)
        else $error("redirect without cause");
    AST_TRIGGER_PRIV: assert property (csr_req.valid && csr_req.addr[11:4] == 8'h7a &&
        !debug_mode && !machine_mode |-> csr_illegal) else $error("trigger access not refused");
    AST_PENDING_MASK: assert property ((irq_enabled_pending & 32'h0000_f777) == 32'h0)
        else $error("pending outside implemented lines");
    AST_PENDING_FOLLOW: assert property (($stable(irq_lines) && $stable(irq_enable))[*5]
        |-> irq_enabled_pending == (irq_lines & 32'hffff_0888 & irq_enable))
        else $error("pending does not follow lines");
    AST_BREAK_CAUSE: assert property (debug_enter |-> $past(fetch_valid) &&
        !$past(debug_mode)) else $error("debug entry without fetch");
    AST_TVAL_ZERO: assert property (csr_req.valid && csr_req.addr == ADDR_TRAP_VALUE
        |=> csr_rdata == 32'h0) else $error("trap value not zero");
    AST_RDATA_HOLD: assert property (!$past(csr_req.valid) |-> $stable(csr_rdata))
        else $error("read data changed while idle");
endmodule
bind trap_and_trigger_csr_bank trap_and_trigger_csr_bank_asserts
    #(.FAST_IRQ_W(FAST_IRQ_W)) u_chk (
    .clk, .reset, .csr_req, .debug_mode, .machine_mode, .csr_rdata, .csr_illegal,
    .trap_event, .trap_return, .trap_vector, .irq_lines, .irq_enable, .irq_enabled_pending,
    .fetch_valid, .fetch_addr, .pc_redirect, .pc_redirect_addr, .debug_enter
);
